//--- logic/pcsia_pkg.sv
// Shared constants, field layouts and carrier types of the program sequencer
package pcsia_pkg;

  // Widths
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int HOLD_W = 5;
  localparam int TGT_W = 11;
  localparam int IADDR_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  // Register offsets on the core register port
  localparam logic [7:0] REG_SLOT = 8'h00;
  localparam logic [7:0] REG_LOW_BYTE = 8'h02;
  localparam logic [7:0] REG_BANK = 8'h03;
  localparam logic [7:0] REG_POINTER = 8'h04;
  localparam logic [7:0] REG_HOLD = 8'h0a;

  // Field positions
  localparam int BANK_BIT_POS = 7;
  localparam int HOLD_JUMP_HI = 4;
  localparam int HOLD_JUMP_LO = 3;

  // Reset and fixed values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 5'h00;
  localparam logic [LOW_W-1:0] PTR_RESET = 8'h00;
  localparam logic BANK_RESET = 1'b0;
  localparam logic [LOW_W-1:0] SELF_READ_VALUE = 8'h00;
  localparam logic [LOW_W-1:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;

  // Sequencing requests from the instruction decoder
  typedef struct packed {
    logic intr;
    logic call;
    logic jump;
    logic ret;
    logic add;
    logic step;
    logic [TGT_W-1:0] target;
    logic [LOW_W-1:0] offset;
  } pcsia_op_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [LOW_W-1:0] wdata;
    logic wr;
    logic rd;
  } pcsia_bus_t;

  // Indirect write toward data memory
  typedef struct packed {
    logic wr;
    logic [IADDR_W-1:0] waddr;
    logic [LOW_W-1:0] wdata;
  } pcsia_mem_t;

  // Return stack state
  typedef struct packed {
    logic [STACK_DEPTH-1:0][PC_W-1:0] slot;
    logic [SP_W-1:0] ptr;
  } pcsia_stack_t;

  // Sequencer state
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [HOLD_W-1:0] hold;
    logic [LOW_W-1:0] fptr;
    logic bank;
    logic [LOW_W-1:0] rdata;
    pcsia_mem_t mem;
  } pcsia_state_t;

  // Register decode used by the write strobes and the self-reference detect; the read mux decodes with a case
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Eight-bit add that wraps inside the low byte
  function automatic logic [LOW_W-1:0] add8(input logic [LOW_W-1:0] a,
                                            input logic [LOW_W-1:0] b);
    logic [LOW_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    add8 = s[LOW_W-1:0];
  endfunction : add8

endpackage : pcsia_pkg

//--- logic/pcsia_ind_addr.sv
// Indirect address former: bank bit over file pointer, plus self-reference detect
`timescale 1ns/1ns
module pcsia_ind_addr (
  // Pointer state
  input wire logic bank,
  input wire logic [pcsia_pkg::LOW_W-1:0] fptr,
  // Formed address
  output logic [pcsia_pkg::IADDR_W-1:0] addr,
  output logic self_ref
);

  // Bank bit on top picks banks 2 and 3 when set
  assign addr = {bank, fptr};

  // Pointer aimed back at the slot itself, in any bank
  assign self_ref = pcsia_pkg::hit(fptr, pcsia_pkg::REG_SLOT);

endmodule : pcsia_ind_addr

//--- logic/pcsia_ret_stack.sv
// Eight-entry circular return stack with a hidden pointer
`timescale 1ns/1ns
module pcsia_ret_stack (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [pcsia_pkg::PC_W-1:0] push_val,
  // Entry on top
  output logic [pcsia_pkg::PC_W-1:0] top
);

  pcsia_pkg::pcsia_stack_t r;
  pcsia_pkg::pcsia_stack_t next_r;

  // Pointer wraps freely; no overflow or underflow flag exists
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.slot[r.ptr] = push_val;
      next_r.ptr = r.ptr + pcsia_pkg::SP_STEP;
    end else if (pop) begin
      next_r.ptr = r.ptr - pcsia_pkg::SP_STEP;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r.slot <= '0;
      r.ptr <= pcsia_pkg::SP_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Most recent push
  assign top = r.slot[r.ptr - pcsia_pkg::SP_STEP];

  // Ninth push lands on the first slot again
  a_stack_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
    push |=> (r.ptr == $past(r.ptr) + pcsia_pkg::SP_STEP))
    else $error("stack pointer did not advance on push");

  a_push_top: assert property (@(posedge mclk) disable iff (sys_rst)
    push |=> (top == $past(push_val)))
    else $error("pushed value not on top");

endmodule : pcsia_ret_stack

//--- logic/pcsia_seq.sv
// Program counter, return stack control and indirect access slot of the core
//
// Function
// - Program counter is thirteen bits wide and addresses program memory.
// - Low byte is a register; upper five bits have no register and load from the holding latch on low-byte writes.
// - Every reset clears the whole program counter.
// - Low-byte write loads the byte and copies holding bits four to zero high.
// - Call or jump takes counter bits twelve and eleven from holding bits four, three.
// - Computed jump adds an offset to the low byte, wrapping within it.
// - Eight-entry thirteen-bit return stack, outside memory, with a hidden pointer.
// - Calls and interrupt vectoring push the program counter.
// - Return, return with literal and return from interrupt pop the stack.
// - Push and pop leave the holding latch unchanged.
// - Stack is circular; the ninth push overwrites the first entry.
// - No overflow or underflow status is provided.
// - Naming the indirect slot accesses the location the file pointer addresses.
// - Reading the slot through itself returns zero.
// - Writing the slot through itself writes nothing.
// - Indirect address is the bank bit over the eight-bit file pointer.
// - Bank bit set selects banks two and three; clear selects zero and one.
`timescale 1ns/1ns
module pcsia_seq #(
  parameter logic [12:0] INTR_VECTOR = 13'h0010
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Sequencing requests from the decoder
  input wire pcsia_pkg::pcsia_op_t op,
  // Register port
  input wire pcsia_pkg::pcsia_bus_t bus,
  output logic [pcsia_pkg::LOW_W-1:0] rdata,
  // Data memory
  output logic [pcsia_pkg::IADDR_W-1:0] mem_addr,
  input wire logic [pcsia_pkg::LOW_W-1:0] mem_rdata,
  output pcsia_pkg::pcsia_mem_t mem_wr,
  // Program memory address
  output logic [pcsia_pkg::PC_W-1:0] pc
);

  pcsia_pkg::pcsia_state_t r;
  pcsia_pkg::pcsia_state_t next_r;

  // Stack hookup
  logic push;
  logic pop;
  logic [pcsia_pkg::PC_W-1:0] push_val;
  logic [pcsia_pkg::PC_W-1:0] stack_top;

  // Indirect address and self-reference
  logic [pcsia_pkg::IADDR_W-1:0] ind_addr;
  logic self_ref;

  // Decoded register port strobes
  logic wr_low;
  logic wr_hold;
  logic wr_fptr;
  logic wr_bank;
  logic wr_slot;
  logic rd_slot;

  // Sequential address and computed-jump low byte
  logic [pcsia_pkg::PC_W-1:0] pc_inc;
  logic [pcsia_pkg::LOW_W-1:0] low_sum;

  // Return stack
  pcsia_ret_stack u_stack (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .push(push),
    .pop(pop),
    .push_val(push_val),
    .top(stack_top)
  );

  // Indirect address former
  pcsia_ind_addr u_ind (
    .bank(r.bank),
    .fptr(r.fptr),
    .addr(ind_addr),
    .self_ref(self_ref)
  );

  // Register port decode
  assign wr_low = bus.wr && pcsia_pkg::hit(bus.addr, pcsia_pkg::REG_LOW_BYTE);
  assign wr_hold = bus.wr && pcsia_pkg::hit(bus.addr, pcsia_pkg::REG_HOLD);
  assign wr_fptr = bus.wr && pcsia_pkg::hit(bus.addr, pcsia_pkg::REG_POINTER);
  assign wr_bank = bus.wr && pcsia_pkg::hit(bus.addr, pcsia_pkg::REG_BANK);
  assign wr_slot = bus.wr && pcsia_pkg::hit(bus.addr, pcsia_pkg::REG_SLOT);
  assign rd_slot = bus.rd && pcsia_pkg::hit(bus.addr, pcsia_pkg::REG_SLOT);

  // Next sequential address and wrapped low-byte sum
  assign pc_inc = r.pc + pcsia_pkg::PC_STEP;
  assign low_sum = pcsia_pkg::add8(r.pc[pcsia_pkg::LOW_W-1:0], op.offset);

  // Program counter selection; interrupt first, then call or jump, return,
  // low-byte write, computed jump, and finally the plain step
  always_comb begin
    next_r = r;
    push = 1'b0;
    pop = 1'b0;
    push_val = r.pc;
    if (op.intr) begin
      // Interrupted instruction is resumed on return
      push = 1'b1;
      push_val = r.pc;
      next_r.pc = INTR_VECTOR;
    end else if (op.call || op.jump) begin
      push = op.call;
      push_val = pc_inc;
      next_r.pc = {r.hold[pcsia_pkg::HOLD_JUMP_HI:pcsia_pkg::HOLD_JUMP_LO],
                   op.target};
    end else if (op.ret) begin
      pop = 1'b1;
      next_r.pc = stack_top;
    end else if (wr_low) begin
      next_r.pc = {r.hold, bus.wdata};
    end else if (op.add) begin
      // Table reads that cross a 256-byte block wrap back to its start
      next_r.pc = {r.hold, low_sum};
    end else if (op.step) begin
      next_r.pc = pc_inc;
    end

    // Holding latch, pointer and bank bit change only by register writes
    if (wr_hold) begin
      next_r.hold = bus.wdata[pcsia_pkg::HOLD_W-1:0];
    end
    if (wr_fptr) begin
      next_r.fptr = bus.wdata;
    end
    if (wr_bank) begin
      next_r.bank = bus.wdata[pcsia_pkg::BANK_BIT_POS];
    end

    // Indirect write goes to data memory unless the pointer aims at the slot
    next_r.mem.wr = 1'b0;
    if (wr_slot && !self_ref) begin
      next_r.mem.wr = 1'b1;
      next_r.mem.waddr = ind_addr;
      next_r.mem.wdata = bus.wdata;
    end

    // Read data stand only in the cycle after the read strobe
    next_r.rdata = pcsia_pkg::UNMAPPED_VALUE;
    if (bus.rd) begin
      case (bus.addr)
        pcsia_pkg::REG_SLOT: begin
          if (self_ref) begin
            next_r.rdata = pcsia_pkg::SELF_READ_VALUE;
          end else begin
            next_r.rdata = mem_rdata;
          end
        end
        pcsia_pkg::REG_LOW_BYTE: begin
          next_r.rdata = r.pc[pcsia_pkg::LOW_W-1:0];
        end
        pcsia_pkg::REG_HOLD: begin
          next_r.rdata = {3'h0, r.hold};
        end
        pcsia_pkg::REG_POINTER: begin
          next_r.rdata = r.fptr;
        end
        pcsia_pkg::REG_BANK: begin
          next_r.rdata = {r.bank, 7'h00};
        end
        default: begin
          next_r.rdata = pcsia_pkg::UNMAPPED_VALUE;
        end
      endcase
    end
  end

  // State register; any reset clears the program counter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r.pc <= pcsia_pkg::PC_RESET;
      r.hold <= pcsia_pkg::HOLD_RESET;
      r.fptr <= pcsia_pkg::PTR_RESET;
      r.bank <= pcsia_pkg::BANK_RESET;
      r.rdata <= pcsia_pkg::UNMAPPED_VALUE;
      r.mem <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign pc = r.pc;
  assign rdata = r.rdata;
  assign mem_addr = {r.bank, r.fptr};
  assign mem_wr = r.mem;

  // Checks on the sequencer
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // A call followed by a return
  sequence s_call_then_ret;
    (op.call && !op.intr) ##1 (op.ret && !op.intr && !op.call && !op.jump);
  endsequence

  // Interrupt vectoring followed by a return
  sequence s_intr_then_ret;
    op.intr ##1 (op.ret && !op.intr && !op.call && !op.jump);
  endsequence

  // A low-byte write with no higher-priority request beside it
  sequence s_plain_low_write;
    wr_low && !op.intr && !op.call && !op.jump && !op.ret;
  endsequence

  // A return with no higher-priority request beside it
  sequence s_plain_ret;
    op.ret && !op.intr && !op.call && !op.jump;
  endsequence

  // No request at all, so the counter must hold
  sequence s_idle;
    !op.intr && !op.call && !op.jump && !op.ret && !op.add && !op.step && !wr_low;
  endsequence

  a_pc_reset_zero: assert property (@(posedge mclk) disable iff (1'b0)
    sys_rst |=> (pc == 13'h0000))
    else $error("program counter not cleared by reset");

  a_low_write_load: assert property (s_plain_low_write |=>
    (pc == {$past(r.hold), $past(bus.wdata)}))
    else $error("low-byte write did not load counter");

  a_jump_target: assert property ((op.jump || op.call) && !op.intr |=>
    (pc[12:11] == $past(r.hold[4:3])) && (pc[10:0] == $past(op.target)))
    else $error("jump target or page bits wrong");

  a_call_return: assert property (s_call_then_ret |=>
    (pc == $past(pc, 2) + 13'h0001))
    else $error("return did not resume after call");

  a_intr_push: assert property (s_intr_then_ret |=>
    (pc == $past(pc, 2)))
    else $error("interrupt return address wrong");

  a_add_wrap: assert property (op.add && !op.intr && !op.call && !op.jump
    && !op.ret && !wr_low |=>
    (pc[7:0] == pcsia_pkg::add8($past(r.pc[7:0]), $past(op.offset)))
    && (pc[12:8] == $past(r.hold)))
    else $error("computed jump sum wrong");

  a_hold_stable: assert property ((push || pop) && !wr_hold |=>
    $stable(r.hold))
    else $error("stack operation changed holding latch");

  a_self_read_zero: assert property (rd_slot && self_ref |=>
    (rdata == 8'h00))
    else $error("self read of slot not zero");

  a_self_write_none: assert property (wr_slot && self_ref |=>
    !mem_wr.wr)
    else $error("self write of slot reached memory");

  a_ind_write: assert property (wr_slot && !self_ref |=>
    mem_wr.wr && (mem_wr.waddr == {$past(r.bank), $past(r.fptr)})
    ##1 !mem_wr.wr || $past(wr_slot))
    else $error("indirect write address wrong");

  a_bank_half: assert property (r.bank |->
    (mem_addr >= 9'h100))
    else $error("bank bit does not select upper half");

  a_read_once: assert property (!bus.rd |=> (rdata == 8'h00))
    else $error("read data stood outside its cycle");

  // Plain step advances by one
  a_step_inc: assert property (op.step && !op.intr && !op.call && !op.jump
    && !op.ret && !op.add && !wr_low |=> (pc == $past(pc) + 13'h0001))
    else $error("step did not advance counter");

  // With no request the counter holds its value
  a_idle_hold: assert property (s_idle |=> $stable(pc))
    else $error("counter moved with no request");

  // A return loads the full entry from the stack
  a_ret_pop: assert property (s_plain_ret |=> (pc == $past(stack_top)))
    else $error("return did not load stack entry");

  // A return pops and never pushes
  a_ret_pops: assert property (s_plain_ret |-> pop && !push)
    else $error("return did not pop");

  // Interrupt vectoring lands on the vector
  a_intr_vector: assert property (op.intr |=> (pc == INTR_VECTOR))
    else $error("interrupt did not reach vector");

  // A call pushes and never pops
  a_call_push: assert property (op.call && !op.intr |-> push && !pop)
    else $error("call did not push");

  // A jump touches the stack not at all
  a_jump_no_push: assert property (op.jump && !op.call && !op.intr |->
    !push && !pop)
    else $error("jump touched the stack");

  // Pointer register takes the written byte
  a_fptr_write: assert property (wr_fptr |=> (r.fptr == $past(bus.wdata)))
    else $error("file pointer write lost");

  // Bank bit takes bit seven of the written byte
  a_bank_write: assert property (wr_bank |=> (r.bank == $past(bus.wdata[7])))
    else $error("bank bit write lost");

  // Holding latch takes the low five bits
  a_hold_write: assert property (wr_hold |=>
    (r.hold == $past(bus.wdata[4:0])))
    else $error("holding latch write lost");

  // Slot read through a foreign pointer returns memory data
  a_ind_read: assert property (rd_slot && !self_ref |=>
    (rdata == $past(mem_rdata)))
    else $error("indirect read data wrong");

  // Low byte reads back the counter
  a_low_read: assert property (bus.rd && (bus.addr == pcsia_pkg::REG_LOW_BYTE) |=>
    (rdata == $past(r.pc[7:0])))
    else $error("low byte read wrong");

  // Computed jump never touches the stack
  a_add_no_stack: assert property (op.add && !op.intr && !op.call && !op.jump
    && !op.ret |-> !push && !pop)
    else $error("computed jump touched the stack");

endmodule : pcsia_seq

//--- verification/pcsia_dmem_model.sv
// Behavioural data memory that answers the indirect access port
`timescale 1ns/1ns
module pcsia_dmem_model (
  // Clock
  input wire logic mclk,
  // Indirect access port
  input wire logic [pcsia_pkg::IADDR_W-1:0] mem_addr,
  output logic [pcsia_pkg::LOW_W-1:0] mem_rdata,
  input wire pcsia_pkg::pcsia_mem_t mem_wr
);
  logic [pcsia_pkg::LOW_W-1:0] mem [512];

  // Distinct fill so a zero from the slot cannot come from memory
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0] ^ 8'ha5;
    end
  end

  // Combinational read of the formed address
  assign mem_rdata = mem[mem_addr];

  // Write on the one-cycle pulse
  always @(posedge mclk) begin
    if (mem_wr.wr === 1'b1) begin
      mem[mem_wr.waddr] <= mem_wr.wdata;
    end
  end
endmodule : pcsia_dmem_model

//--- verification/tb_pc_stack_indirect_addr.sv
// Self-checking bench for the program sequencer and indirect slot
`timescale 1ns/1ns
module tb_pc_stack_indirect_addr;
  localparam logic [12:0] VEC = 13'h0040;
  localparam logic [5:0] K_INT = 6'h20;
  localparam logic [5:0] K_CALL = 6'h10;
  localparam logic [5:0] K_JMP = 6'h08;
  localparam logic [5:0] K_RET = 6'h04;
  localparam logic [5:0] K_ADD = 6'h02;
  localparam logic [5:0] K_STEP = 6'h01;
  logic mclk;
  logic sys_rst;
  pcsia_pkg::pcsia_op_t op;
  pcsia_pkg::pcsia_bus_t bus;
  logic [7:0] rdata;
  logic [8:0] mem_addr;
  logic [7:0] mem_rdata;
  pcsia_pkg::pcsia_mem_t mem_wr;
  pcsia_pkg::pcsia_mem_t last_mw;
  logic [12:0] pc;
  logic [12:0] ring [8];
  logic [2:0] rp;
  logic [12:0] epc;
  int failures;
  int checks_done;

  // Design and data memory
  pcsia_seq #(.INTR_VECTOR(VEC)) pcsia_seq_inst (.mclk(mclk), .sys_rst(sys_rst), .op(op),
    .bus(bus), .rdata(rdata), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .pc(pc));
  pcsia_dmem_model pcsia_dmem_model_inst (.mclk(mclk), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_wr(mem_wr));

  // 250 MHz clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One write cycle; captures the indirect write pulse that follows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
    #1 last_mw = mem_wr;
  endtask : wr

  // One read cycle; data checked in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 chk(rdata, exp, "read data");
  endtask : rd

  // One sequencing request, then the new program counter
  task automatic do_op(input logic [5:0] k, input logic [10:0] t, input logic [7:0] o,
                       input logic [12:0] exp);
    @(posedge mclk);
    op <= {k, t, o};
    @(posedge mclk);
    op <= '0;
    #1 chk(pc, exp, "program counter");
  endtask : do_op

  // Verdict
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    close_out;
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    op = '0;
    bus = '0;
    failures = 0;
    checks_done = 0;
    rp = 3'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    #1 chk(pc, 13'h0000, "pc after reset");
    rd(pcsia_pkg::REG_LOW_BYTE, 8'h00);
    $display("test reset done");
    // Low byte write, holding latch, jump, add and step
    wr(pcsia_pkg::REG_HOLD, 8'h18);
    wr(pcsia_pkg::REG_LOW_BYTE, 8'h34);
    chk(pc, 13'h1834, "pc after low write");
    rd(pcsia_pkg::REG_LOW_BYTE, 8'h34);
    wr(pcsia_pkg::REG_HOLD, 8'hff);
    rd(pcsia_pkg::REG_HOLD, 8'h1f);
    wr(pcsia_pkg::REG_HOLD, 8'h08);
    do_op(K_JMP, 11'h7ff, 8'h00, 13'h0fff);
    wr(pcsia_pkg::REG_LOW_BYTE, 8'hf0);
    do_op(K_ADD, 11'h000, 8'h20, 13'h0810);
    do_op(K_STEP, 11'h000, 8'h00, 13'h0811);
    $display("test counter done");
    // Call, return, interrupt
    do_op(K_CALL, 11'h055, 8'h00, 13'h0855);
    rd(pcsia_pkg::REG_HOLD, 8'h08);
    wr(pcsia_pkg::REG_HOLD, 8'h10);
    do_op(K_RET, 11'h000, 8'h00, 13'h0812);
    rd(pcsia_pkg::REG_HOLD, 8'h10);
    do_op(K_INT, 11'h000, 8'h00, VEC);
    do_op(K_RET, 11'h000, 8'h00, 13'h0812);
    // Call then return, and interrupt then return, back to back
    @(posedge mclk);
    op <= {K_CALL, 11'h022, 8'h00};
    @(posedge mclk);
    op <= {K_RET, 11'h000, 8'h00};
    @(posedge mclk);
    op <= {K_INT, 11'h000, 8'h00};
    #1 chk(pc, 13'h0813, "call then return");
    @(posedge mclk);
    op <= {K_RET, 11'h000, 8'h00};
    #1 chk(pc, VEC, "interrupt vector");
    @(posedge mclk);
    op <= '0;
    #1 chk(pc, 13'h0813, "interrupt then return");
    $display("test call done");
    // Nine pushes wrap the eight-entry ring, ten pops walk it back
    epc = 13'h0813;
    for (int i = 0; i < 9; i++) begin
      ring[rp] = epc + 13'h0001;
      rp = rp + 3'h1;
      epc = 13'h1100 + 13'(i);
      do_op(K_CALL, 11'h100 + 11'(i), 8'h00, epc);
    end
    for (int i = 0; i < 10; i++) begin
      rp = rp - 3'h1;
      do_op(K_RET, 11'h000, 8'h00, ring[rp]);
    end
    $display("test stack done");
    // Indirect access in both banks and through itself
    wr(pcsia_pkg::REG_POINTER, 8'h20);
    wr(pcsia_pkg::REG_BANK, 8'h80);
    wr(pcsia_pkg::REG_SLOT, 8'h55);
    chk(last_mw, {1'b1, 9'h120, 8'h55}, "indirect write");
    chk(mem_addr, 9'h120, "upper bank address");
    rd(pcsia_pkg::REG_BANK, 8'h80);
    rd(pcsia_pkg::REG_SLOT, 8'h55);
    wr(pcsia_pkg::REG_BANK, 8'h00);
    rd(pcsia_pkg::REG_SLOT, 8'h85);
    chk(mem_addr, 9'h020, "lower bank address");
    wr(pcsia_pkg::REG_POINTER, 8'h00);
    rd(pcsia_pkg::REG_SLOT, 8'h00);
    wr(pcsia_pkg::REG_SLOT, 8'h77);
    chk(last_mw.wr, 1'b0, "self write pulse");
    rd(8'h7e, 8'h00);
    $display("test indirect done");
    // Reset in mid-run
    wr(pcsia_pkg::REG_POINTER, 8'h33);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1 chk(pc, 13'h0000, "pc after second reset");
    rd(pcsia_pkg::REG_HOLD, 8'h00);
    rd(pcsia_pkg::REG_POINTER, 8'h00);
    $display("test second reset done");
    close_out;
  end
endmodule : tb_pc_stack_indirect_addr
